// ===== pkg/irq_router_consts.svh
`ifndef IRQ_ROUTER_CONSTS_SVH
`define IRQ_ROUTER_CONSTS_SVH

// register offsets on the register port
`define OFF_SOURCE_STATUS 8'h0C
`define OFF_PIN_ELECTRICAL 8'h2C
`define OFF_SOURCE_ENABLE 8'h2D
`define OFF_PIN_ROUTING 8'h2E
`define OFF_EVENT_STATUS 8'h40
`define OFF_EVENT_MASK 8'h41
`define OFF_PIN_STATE 8'h42

// source bit positions, shared by every per-source register
`define BIT_SLEEP_WAKE 7
`define BIT_TRANSIENT 5
`define BIT_ORIENTATION 4
`define BIT_PULSE 3
`define BIT_FALL_MOTION 2
`define BIT_SAMPLE_READY 0

// bits of the pin electrical configuration register
`define BIT_IRQ_POLARITY 1
`define BIT_OPEN_DRAIN 0

// bits of the pin state register
`define BIT_PIN_A_STATE 0
`define BIT_PIN_B_STATE 1

// implemented source bits; bits 6 and 1 always read zero
`define SOURCE_BITS_MASK 8'hBD

// reset values
`define RST_SOURCE_ENABLE 8'h00
`define RST_PIN_ROUTING 8'h00
`define RST_PIN_ELECTRICAL 8'h00
`define RST_EVENT_MASK 8'h00
`define RST_EVENT_STATUS 8'h00
`define RST_READ_DATA 8'h00

// number of interrupt pins
`define IRQ_PIN_COUNT 2
`define PIN_A_INDEX 0
`define PIN_B_INDEX 1

`endif

// ===== pkg/irq_router_pkg.sv
package irq_router_pkg;

   // one bit per source, laid out as in every per-source register
   typedef struct packed {
      logic sleep_wake;
      logic unused6;
      logic transient;
      logic orientation;
      logic pulse;
      logic fall_motion;
      logic unused1;
      logic sample_ready;
   } src_vec_t;

   // one register port request, sampled on the rising edge
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } bus_req_t;

   // electrical behaviour of both interrupt pins
   typedef struct packed {
      logic irq_polarity_select;
      logic open_drain;
   } pin_cfg_t;

   // keeps only the six implemented source bits
   function automatic src_vec_t keep_sources(input logic [7:0] v);
      keep_sources = src_vec_t'(v & 8'hBD);
   endfunction : keep_sources

endpackage : irq_router_pkg

// ===== core/router_regs.sv
`timescale 1ns/10ps
`include "irq_router_consts.svh"

module router_regs (
   input wire logic clk,
   input wire logic rst,
   input wire irq_router_pkg::bus_req_t bus_req,
   output irq_router_pkg::src_vec_t source_enable,
   output irq_router_pkg::src_vec_t pin_routing,
   output irq_router_pkg::pin_cfg_t pin_cfg,
   output irq_router_pkg::src_vec_t event_mask
);
   import irq_router_pkg::*;

   src_vec_t next_source_enable;
   src_vec_t next_pin_routing;
   pin_cfg_t next_pin_cfg;
   src_vec_t next_event_mask;
   logic [7:0] cfg_wdata;

   assign cfg_wdata = bus_req.wdata;

   // software writes; reserved source bits are dropped on the way in
   always_comb begin
      next_source_enable = source_enable;
      next_pin_routing = pin_routing;
      next_pin_cfg = pin_cfg;
      next_event_mask = event_mask;
      if (bus_req.wr) begin
         case (bus_req.addr)
            `OFF_SOURCE_ENABLE: begin
               next_source_enable = keep_sources(bus_req.wdata);
            end
            `OFF_PIN_ROUTING: begin
               next_pin_routing = keep_sources(bus_req.wdata);
            end
            `OFF_PIN_ELECTRICAL: begin
               next_pin_cfg.irq_polarity_select =
                  cfg_wdata[`BIT_IRQ_POLARITY];
               next_pin_cfg.open_drain = cfg_wdata[`BIT_OPEN_DRAIN];
            end
            `OFF_EVENT_MASK: begin
               next_event_mask = keep_sources(bus_req.wdata);
            end
            default: begin
               next_source_enable = source_enable;
            end
         endcase
      end
   end

   // enables and routing both come up cleared
   always_ff @(posedge clk) begin
      if (rst) begin
         source_enable <= src_vec_t'(`RST_SOURCE_ENABLE);
         pin_routing <= src_vec_t'(`RST_PIN_ROUTING);
         pin_cfg <= pin_cfg_t'(2'(`RST_PIN_ELECTRICAL));
         event_mask <= src_vec_t'(`RST_EVENT_MASK);
      end else begin
         source_enable <= next_source_enable;
         pin_routing <= next_pin_routing;
         pin_cfg <= next_pin_cfg;
         event_mask <= next_event_mask;
      end
   end

endmodule : router_regs

// ===== core/irq_pin_driver.sv
`timescale 1ns/10ps

module irq_pin_driver (
   input wire logic clk,
   input wire logic rst,
   input wire logic active,
   input wire irq_router_pkg::pin_cfg_t pin_cfg,
   output logic pin_out,
   output logic pin_oe,
   output logic asserted
);
   import irq_router_pkg::*;

   logic next_pin_out;
   logic next_pin_oe;
   logic level;

   // asserted level follows the polarity bit; open drain only pulls low,
   // so an active-high open-drain pin needs a pull-up to show assertion
   always_comb begin
      level = active ? pin_cfg.irq_polarity_select
                     : ~pin_cfg.irq_polarity_select;
      if (pin_cfg.open_drain) begin
         next_pin_out = 1'b0;
         next_pin_oe = ~level;
      end else begin
         next_pin_out = level;
         next_pin_oe = 1'b1;
      end
   end

   // registered so the pin never glitches on source changes
   always_ff @(posedge clk) begin
      if (rst) begin
         pin_out <= 1'b1; // idle high: deasserted for default polarity
         pin_oe <= 1'b1;
         asserted <= 1'b0;
      end else begin
         pin_out <= next_pin_out;
         pin_oe <= next_pin_oe;
         asserted <= active;
      end
   end

endmodule : irq_pin_driver

// ===== core/sensor_interrupt_router.sv
//
// Behaviour
// - six enable bits gate each source flag
// - all enable bits clear after reset
// - routing bit 1 selects pin a, 0 pin b
// - all routing bits clear after reset
// - each pin is OR of its routed sources
// - routing bits at 7,5,4,3,2,0; 6,1 zero
// - polarity 0 drives assertion low, 1 high
`timescale 1ns/10ps
`include "irq_router_consts.svh"

module sensor_interrupt_router (
   input wire logic clk,
   input wire logic rst,
   input wire irq_router_pkg::src_vec_t src_flags,
   input wire irq_router_pkg::bus_req_t bus_req,
   output logic [7:0] bus_rdata,
   output logic irq_pin_a_out,
   output logic irq_pin_a_oe,
   output logic irq_pin_b_out,
   output logic irq_pin_b_oe,
   output logic event_irq
);
   import irq_router_pkg::*;

   // register contents
   src_vec_t source_enable;
   src_vec_t pin_routing;
   pin_cfg_t pin_cfg;
   src_vec_t event_mask;

   // qualified and routed source flags
   src_vec_t enabled_flags;
   src_vec_t to_pin_a;
   src_vec_t to_pin_b;
   logic [`IRQ_PIN_COUNT-1:0] pin_active;
   logic [`IRQ_PIN_COUNT-1:0] pin_out_vec;
   logic [`IRQ_PIN_COUNT-1:0] pin_oe_vec;
   logic [`IRQ_PIN_COUNT-1:0] pin_asserted;

   // event capture state
   src_vec_t prev_enabled;
   src_vec_t next_prev_enabled;
   src_vec_t event_rise;
   src_vec_t event_status;
   src_vec_t next_event_status;
   logic next_event_irq;
   logic status_read;

   // read path state
   logic [7:0] next_bus_rdata;

   // writable registers live in their own bank
   router_regs u_regs (
      .clk(clk),
      .rst(rst),
      .bus_req(bus_req),
      .source_enable(source_enable),
      .pin_routing(pin_routing),
      .pin_cfg(pin_cfg),
      .event_mask(event_mask)
   );

   // a flag only goes further while its source is enabled; the flags come
   // from detector logic on this same clock, so no synchroniser is needed
   always_comb begin
      enabled_flags = keep_sources(src_flags & source_enable);
   end

   // split the enabled flags by their routing bit
   always_comb begin
      to_pin_a = keep_sources(enabled_flags & pin_routing);
      to_pin_b = keep_sources(enabled_flags & ~pin_routing);
   end

   // a pin is active while any routed flag is still set, so it releases
   // only when the last one clears; sharing is why software must look at
   // the source register after an assertion
   always_comb begin
      pin_active[`PIN_A_INDEX] = |to_pin_a;
      pin_active[`PIN_B_INDEX] = |to_pin_b;
   end

   // one driver per pin, same polarity and drive style for both
   genvar gp;
   generate
      for (gp = 0; gp < `IRQ_PIN_COUNT; gp = gp + 1) begin : g_pin
         irq_pin_driver u_drv (
            .clk(clk),
            .rst(rst),
            .active(pin_active[gp]),
            .pin_cfg(pin_cfg),
            .pin_out(pin_out_vec[gp]),
            .pin_oe(pin_oe_vec[gp]),
            .asserted(pin_asserted[gp])
         );
      end
   endgenerate

   // pin a is the first interrupt pin, pin b the second
   assign irq_pin_a_out = pin_out_vec[`PIN_A_INDEX];
   assign irq_pin_a_oe = pin_oe_vec[`PIN_A_INDEX];
   assign irq_pin_b_out = pin_out_vec[`PIN_B_INDEX];
   assign irq_pin_b_oe = pin_oe_vec[`PIN_B_INDEX];

   // a read of the event status register clears it
   assign status_read = bus_req.rd && (bus_req.addr == `OFF_EVENT_STATUS);

   // rising edges of enabled flags are the events; a new edge in the
   // cycle of the clearing read survives, so no event is ever lost
   always_comb begin
      next_prev_enabled = enabled_flags;
      event_rise = keep_sources(enabled_flags & ~prev_enabled);
      if (status_read) begin
         next_event_status = event_rise;
      end else begin
         next_event_status = keep_sources(event_status | event_rise);
      end
      next_event_irq = |(next_event_status & event_mask);
   end

   // event capture registers
   always_ff @(posedge clk) begin
      if (rst) begin
         prev_enabled <= src_vec_t'(`RST_EVENT_STATUS);
         event_status <= src_vec_t'(`RST_EVENT_STATUS);
         event_irq <= 1'b0;
      end else begin
         prev_enabled <= next_prev_enabled;
         event_status <= next_event_status;
         event_irq <= next_event_irq;
      end
   end

   // read data stands only in the cycle after the read strobe;
   // unmapped addresses read zero
   always_comb begin
      next_bus_rdata = `RST_READ_DATA;
      if (bus_req.rd) begin
         case (bus_req.addr)
            `OFF_SOURCE_STATUS: begin
               next_bus_rdata = enabled_flags;
            end
            `OFF_PIN_ELECTRICAL: begin
               next_bus_rdata[`BIT_IRQ_POLARITY] =
                  pin_cfg.irq_polarity_select;
               next_bus_rdata[`BIT_OPEN_DRAIN] = pin_cfg.open_drain;
            end
            `OFF_SOURCE_ENABLE: begin
               next_bus_rdata = source_enable;
            end
            `OFF_PIN_ROUTING: begin
               next_bus_rdata = pin_routing;
            end
            `OFF_EVENT_STATUS: begin
               next_bus_rdata = event_status;
            end
            `OFF_EVENT_MASK: begin
               next_bus_rdata = event_mask;
            end
            `OFF_PIN_STATE: begin
               next_bus_rdata[`BIT_PIN_A_STATE] =
                  pin_asserted[`PIN_A_INDEX];
               next_bus_rdata[`BIT_PIN_B_STATE] =
                  pin_asserted[`PIN_B_INDEX];
            end
            default: begin
               next_bus_rdata = `RST_READ_DATA;
            end
         endcase
      end
   end

   // read data register
   always_ff @(posedge clk) begin
      if (rst) begin
         bus_rdata <= `RST_READ_DATA;
      end else begin
         bus_rdata <= next_bus_rdata;
      end
   end

endmodule : sensor_interrupt_router

// ===== bench/host_irq_model.sv
`timescale 1ns/10ps

module host_irq_model (
   input wire logic a_out,
   input wire logic a_oe,
   input wire logic b_out,
   input wire logic b_oe,
   output logic level_a,
   output logic level_b
);
   // the host's inputs sit on pulled-up lines, so a released pin reads high
   assign level_a = a_oe ? a_out : 1'b1;
   assign level_b = b_oe ? b_out : 1'b1;
endmodule : host_irq_model

// ===== bench/router_asserts.sv
`timescale 1ns/10ps
`include "irq_router_consts.svh"

module router_checker (
   input wire logic clk,
   input wire logic rst,
   input wire irq_router_pkg::src_vec_t src_flags,
   input wire irq_router_pkg::bus_req_t bus_req,
   input wire logic [7:0] bus_rdata,
   input wire logic irq_pin_a_out,
   input wire logic irq_pin_a_oe,
   input wire logic irq_pin_b_out,
   input wire logic irq_pin_b_oe,
   input wire logic event_irq
);
   import irq_router_pkg::*;
   logic [7:0] en, rt;
   logic pol, od, pol_d;
   // shadow copies of the enable, routing and pin electrical registers, rebuilt from port traffic
   always_ff @(posedge clk) begin
      if (rst) begin
         en <= 8'h00;
         rt <= 8'h00;
         {pol, od} <= 2'h0;
         pol_d <= 1'b0;
      end else begin
         if (bus_req.wr && bus_req.addr == `OFF_SOURCE_ENABLE)
            en <= bus_req.wdata & `SOURCE_BITS_MASK;
         if (bus_req.wr && bus_req.addr == `OFF_PIN_ROUTING)
            rt <= bus_req.wdata & `SOURCE_BITS_MASK;
         if (bus_req.wr && bus_req.addr == `OFF_PIN_ELECTRICAL)
            {pol, od} <= bus_req.wdata[1:0];
         pol_d <= pol; // pins are registered with last cycle's polarity
      end
   end
   // pin judged on the wire level, so open drain needs no special case
   wire logic act_a = |(src_flags & en & rt);
   wire logic act_b = |(src_flags & en & ~rt);
   wire logic on_a = ((irq_pin_a_oe ? irq_pin_a_out : 1'b1) == pol_d);
   wire logic on_b = ((irq_pin_b_oe ? irq_pin_b_out : 1'b1) == pol_d);

   a_pin_a_on: assert property (@(posedge clk) disable iff (rst)
      act_a |=> on_a) else $error("pin a not asserted");
   a_pin_b_on: assert property (@(posedge clk) disable iff (rst)
      act_b |=> on_b) else $error("pin b not asserted");
   a_pin_a_off: assert property (@(posedge clk) disable iff (rst)
      !act_a |=> !on_a) else $error("pin a asserted without cause");
   a_pin_b_off: assert property (@(posedge clk) disable iff (rst)
      !act_b |=> !on_b) else $error("pin b asserted without cause");
   a_hold_pin_a: assert property (@(posedge clk) disable iff (rst)
      act_a [*2] |-> on_a) else $error("pin a dropped while set");
   a_read_enable: assert property (@(posedge clk) disable iff (rst)
      bus_req.rd && bus_req.addr == `OFF_SOURCE_ENABLE |=>
      bus_rdata == $past(en)) else $error("enable readback wrong");
   a_read_routing: assert property (@(posedge clk) disable iff (rst)
      bus_req.rd && bus_req.addr == `OFF_PIN_ROUTING |=>
      bus_rdata == $past(rt)) else $error("routing readback wrong");
   a_drain_no_high: assert property (@(posedge clk) disable iff (rst)
      $past(od) && irq_pin_a_oe |-> !irq_pin_a_out)
      else $error("open drain pin driven high");
   a_reset_idle: assert property (@(posedge clk) disable iff (rst)
      $fell(rst) |-> irq_pin_a_out && irq_pin_a_oe && irq_pin_b_out &&
      irq_pin_b_oe && !event_irq) else $error("pins not idle after reset");
endmodule : router_checker

bind sensor_interrupt_router router_checker u_chk (.clk, .rst, .src_flags,
   .bus_req, .bus_rdata, .irq_pin_a_out, .irq_pin_a_oe, .irq_pin_b_out,
   .irq_pin_b_oe, .event_irq);

// ===== bench/sensor_interrupt_router_tb.sv
`timescale 1ns/10ps
`include "irq_router_consts.svh"

module sensor_interrupt_router_tb;
   import irq_router_pkg::*;
   logic clk, rst;
   src_vec_t flags;
   bus_req_t req;
   logic [7:0] rdata, m;
   logic a_out, a_oe, b_out, b_oe, eirq, lvl_a, lvl_b;
   int n_fail = 0;
   int total_checks = 0;
   int cycles = 0;

   sensor_interrupt_router u_dut (.clk(clk), .rst(rst), .src_flags(flags),
      .bus_req(req), .bus_rdata(rdata), .irq_pin_a_out(a_out),
      .irq_pin_a_oe(a_oe), .irq_pin_b_out(b_out), .irq_pin_b_oe(b_oe),
      .event_irq(eirq));
   host_irq_model u_host (.a_out(a_out), .a_oe(a_oe), .b_out(b_out),
      .b_oe(b_oe), .level_a(lvl_a), .level_b(lvl_b));

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // a hang is cut short well past the 165 or so cycles the run needs
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         n_fail++;
         end_sim();
      end
   end

   task end_sim();
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : end_sim

   task chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk

   // strobes get a idle cycle after them so no signal is set twice at once
   task wr(input logic [7:0] a, input logic [7:0] d);
      req <= {a, d, 2'h2};
      @(posedge clk);
      req <= '0;
      @(posedge clk);
   endtask : wr

   task rd(input logic [7:0] a, input logic [7:0] exp);
      req <= {a, 8'h00, 2'h1};
      @(posedge clk);
      req <= '0;
      #1 chk(rdata, exp);
      @(posedge clk);
   endtask : rd

   // exp holds event irq, then wire levels of pin a and pin b
   task pins(input logic [2:0] exp);
      @(posedge clk);
      #1 chk({5'h00, eirq, lvl_a, lvl_b}, {5'h00, exp});
      @(posedge clk);
   endtask : pins

   initial begin
      rst = 1'b1;
      flags = '0;
      req = '0;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      rd(`OFF_SOURCE_ENABLE, 8'h00);
      rd(`OFF_PIN_ROUTING, 8'h00);
      wr(`OFF_PIN_ROUTING, 8'hFF);
      rd(`OFF_PIN_ROUTING, 8'hBD);
      wr(`OFF_SOURCE_ENABLE, 8'hFF);
      rd(`OFF_SOURCE_ENABLE, 8'hBD);
      rd(8'h10, 8'h00);
      wr(`OFF_SOURCE_ENABLE, 8'h00);
      flags <= src_vec_t'(8'hFF);
      pins(3'h3);
      flags <= '0;
      // every source steered to each pin in turn
      for (int i = 0; i < 8; i++) begin
         m = 8'h01 << i;
         if ((m & `SOURCE_BITS_MASK) != 8'h00) begin
            wr(`OFF_SOURCE_ENABLE, m);
            wr(`OFF_PIN_ROUTING, m);
            flags <= src_vec_t'(m);
            pins(3'h1);
            rd(`OFF_SOURCE_STATUS, m);
            wr(`OFF_PIN_ROUTING, 8'h00);
            pins(3'h2);
            flags <= '0;
            pins(3'h3);
            rd(`OFF_EVENT_STATUS, m);
         end
      end
      wr(`OFF_SOURCE_ENABLE, 8'h05);
      wr(`OFF_PIN_ROUTING, 8'h05);
      flags <= src_vec_t'(8'h05);
      pins(3'h1);
      flags <= src_vec_t'(8'h04);
      pins(3'h1);
      flags <= '0;
      pins(3'h3);
      wr(`OFF_PIN_ELECTRICAL, 8'h02);
      rd(`OFF_PIN_ELECTRICAL, 8'h02);
      pins(3'h0);
      flags <= src_vec_t'(8'h04);
      pins(3'h2);
      wr(`OFF_PIN_ELECTRICAL, 8'h01);
      pins(3'h1);
      flags <= '0;
      wr(`OFF_PIN_ELECTRICAL, 8'h00);
      wr(`OFF_PIN_ROUTING, 8'h00);
      wr(`OFF_EVENT_MASK, 8'h01);
      rd(`OFF_EVENT_MASK, 8'h01);
      // bits 0 and 2 both rose after the last clearing read
      rd(`OFF_EVENT_STATUS, 8'h05);
      flags <= src_vec_t'(8'h01);
      pins(3'h6);
      rd(`OFF_PIN_STATE, 8'h02);
      rd(`OFF_EVENT_STATUS, 8'h01);
      pins(3'h2);
      wr(`OFF_EVENT_MASK, 8'h00);
      flags <= '0;
      pins(3'h3);
      flags <= src_vec_t'(8'h01);
      pins(3'h2);
      rd(`OFF_EVENT_STATUS, 8'h01);
      end_sim();
   end
endmodule : sensor_interrupt_router_tb
